// File: hdl/pbg_port.sv
// Five-line GPIO port with special input functions and Avalon-MM slave
//
// Overview of operation
// [RQ1] Five lines, each direction set independently
// [RQ2] Input lines pass through hysteresis buffer
// [RQ3] Special inputs only on lines 0, 2, 4
// [RQ4] Special function enabled per bit only
// [RQ5] Software clears enables before direction change
// [RQ6] Spurious events on direction change are allowed
// [RQ7] Software sets enables as final step
// [RQ8] Inputs synchronised by two flops first
// [RQ9] Input bits overwrite writes, output bits hold
// [RQ10] Output lines driven, input buffer disabled
// [RQ11] Special outputs gated by enable bits
//
// Register access over Avalon-MM and the address map were decided locally.
`default_nettype none
module pbg_port
  import pbg_pkg::*;
#(
  parameter int LINES = PBG_LINES
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [4:0] PORT_LINE_I,
  output logic [4:0] PORT_LINE_O,
  output logic [4:0] PORT_LINE_OE_O,
  output logic RECOVERY_INPUT_O,
  output logic INTERRUPT_REQUEST_THREE_O,
  output logic INTERRUPT_REQUEST_ONE_OR_FOUR_O,
  output logic IRQ_O
);
  logic [4:0] dir_reg;
  logic [4:0] out_reg;
  logic [4:0] in_reg;
  logic [4:0] special_function_enable_reg;
  logic [4:0] irq_stat_reg;
  logic [4:0] irq_mask_reg;
  logic [4:0] buffered;
  logic [4:0] synced;
  logic [4:0] synced_prev_reg;
  logic [4:0] events;
  logic [4:0] stat_clear;
  logic [31:0] read_word;
  pbg_bus_req_t req;
  pbg_special_t special_next;
  logic wr_hit;
  logic rd_hit;
  logic bus_busy;

  // Bus handshake: one wait cycle, then a single-cycle completion
  typedef enum logic [0:0] {
    PBG_BUS_IDLE = 1'b0,
    PBG_BUS_DONE = 1'b1
  } pbg_bus_state_t;

  pbg_bus_state_t bus_state_reg;
  pbg_bus_state_t bus_state_next;

  function automatic logic [31:0] pbg_widen(input logic [4:0] v);
    pbg_widen = {27'h0000000, v};
  endfunction : pbg_widen

  // True when a qualified access targets the given register
  function automatic logic pbg_select(
    input logic hit,
    input logic [3:0] address,
    input logic [3:0] offset
  );
    pbg_select = hit && (address == offset);
  endfunction : pbg_select

  // One special input: the synced line, passed only while enabled
  function automatic logic pbg_gate(
    input logic [4:0] lines,
    input logic [4:0] enables,
    input int position
  );
    pbg_gate = lines[position] & enables[position];
  endfunction : pbg_gate

  assign req = '{read: AVS_READ_I, write: AVS_WRITE_I,
                 address: AVS_ADDRESS_I, writedata: AVS_WRITEDATA_I};
  assign bus_busy = req.read || req.write;
  // Reads latch on the taking edge, writes land on the finishing edge
  assign wr_hit = req.write && (bus_state_reg == PBG_BUS_DONE);
  assign rd_hit = req.read && (bus_state_reg == PBG_BUS_IDLE);

  // [RQ2] [RQ10] Buffer only on inputs
  pbg_schmitt #(
    .WIDTH(5)
  ) u_schmitt (
    .pad_i(PORT_LINE_I),
    .enable_i(~dir_reg),
    .buf_o(buffered)
  );

  // [RQ8] Two-stage synchroniser
  pbg_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .async_i(buffered),
    .sync_o(synced)
  );

  // Handshake state
  always_comb begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      PBG_BUS_IDLE: begin
        if (bus_busy) begin
          bus_state_next = PBG_BUS_DONE;
        end
      end
      PBG_BUS_DONE: begin
        bus_state_next = PBG_BUS_IDLE;
      end
      default: begin
        bus_state_next = PBG_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bus_state_reg <= PBG_BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // Waitrequest is low exactly while the state reads done
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      AVS_WAITREQUEST_O <= (bus_state_next != PBG_BUS_DONE);
    end
  end

  // Read word selection
  always_comb begin
    read_word = 32'h00000000;
    case (req.address)
      PBG_OFF_INPUT: begin
        read_word = pbg_widen(in_reg);
      end
      PBG_OFF_OUTPUT: begin
        read_word = pbg_widen(out_reg);
      end
      PBG_OFF_DIR: begin
        read_word = pbg_widen(dir_reg);
      end
      PBG_OFF_SFE: begin
        read_word = pbg_widen(special_function_enable_reg);
      end
      PBG_OFF_IRQ_STAT: begin
        read_word = pbg_widen(irq_stat_reg);
      end
      PBG_OFF_IRQ_MASK: begin
        read_word = pbg_widen(irq_mask_reg);
      end
      default: begin
        read_word = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AVS_READDATA_O <= 32'h00000000;
    end else if (rd_hit) begin
      AVS_READDATA_O <= read_word;
    end
  end

  // [RQ1] Per-line direction control
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dir_reg <= PBG_RST_DIR;
    end else if (pbg_select(wr_hit, req.address, PBG_OFF_DIR)) begin
      dir_reg <= req.writedata[4:0];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      out_reg <= PBG_RST_OUTPUT;
    end else if (pbg_select(wr_hit, req.address, PBG_OFF_OUTPUT)) begin
      out_reg <= req.writedata[4:0];
    end
  end

  // [RQ9] Input bits track pins, output bits keep writes
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      in_reg <= 5'h00;
    end else if (pbg_select(wr_hit, req.address, PBG_OFF_INPUT)) begin
      in_reg <= req.writedata[4:0];
    end else begin
      in_reg <= (synced & ~dir_reg) | (in_reg & dir_reg);
    end
  end

  // [RQ3] [RQ4] Only lines 0, 2, 4 hold enable bits
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      special_function_enable_reg <= PBG_RST_SFE;
    end else if (pbg_select(wr_hit, req.address, PBG_OFF_SFE)) begin
      special_function_enable_reg <= req.writedata[4:0] & PBG_SFE_CAPABLE;
    end
  end

  // [RQ10] Drive output lines from output register
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PORT_LINE_O <= PBG_RST_OUTPUT;
    end else begin
      PORT_LINE_O <= out_reg;
    end
  end

  // [RQ1] [RQ10] Driver enable follows direction
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PORT_LINE_OE_O <= PBG_RST_DIR;
    end else begin
      PORT_LINE_OE_O <= dir_reg;
    end
  end

  // [RQ11] Gate special inputs by enable bits
  always_comb begin
    special_next.recovery = pbg_gate(synced,
      special_function_enable_reg, PBG_BIT_RECOVERY);
    special_next.irq_three = pbg_gate(synced,
      special_function_enable_reg, PBG_BIT_IRQ_THREE);
    special_next.irq_one_or_four = pbg_gate(synced,
      special_function_enable_reg, PBG_BIT_IRQ_ONE_OR_FOUR);
  end

  // [RQ6] Direction changes under enable may glitch these
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RECOVERY_INPUT_O <= 1'b0;
    end else begin
      RECOVERY_INPUT_O <= special_next.recovery;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      INTERRUPT_REQUEST_THREE_O <= 1'b0;
    end else begin
      INTERRUPT_REQUEST_THREE_O <= special_next.irq_three;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      INTERRUPT_REQUEST_ONE_OR_FOUR_O <= 1'b0;
    end else begin
      INTERRUPT_REQUEST_ONE_OR_FOUR_O <= special_next.irq_one_or_four;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      synced_prev_reg <= 5'h00;
    end else begin
      synced_prev_reg <= synced;
    end
  end

  // Any change on an input line is an event
  assign events = (synced ^ synced_prev_reg) & ~dir_reg;

  // Write-one clear, applied only on a finishing status write
  assign stat_clear = pbg_select(wr_hit, req.address, PBG_OFF_IRQ_STAT) ?
    req.writedata[4:0] : 5'h00;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_stat_reg <= 5'h00;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~stat_clear) | events;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_mask_reg <= PBG_RST_MASK;
    end else if (pbg_select(wr_hit, req.address, PBG_OFF_IRQ_MASK)) begin
      irq_mask_reg <= req.writedata[4:0];
    end
  end

  // Level interrupt while any unmasked status bit is set
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule : pbg_port
`default_nettype wire

// File: hdl/pbg_pkg.sv
// Package with register map, field layout and types of the port block
`default_nettype none
package pbg_pkg;
  localparam int PBG_LINES = 5;
  localparam logic [3:0] PBG_OFF_INPUT = 4'h0;
  localparam logic [3:0] PBG_OFF_OUTPUT = 4'h1;
  localparam logic [3:0] PBG_OFF_DIR = 4'h2;
  localparam logic [3:0] PBG_OFF_SFE = 4'h3;
  localparam logic [3:0] PBG_OFF_IRQ_STAT = 4'h4;
  localparam logic [3:0] PBG_OFF_IRQ_MASK = 4'h5;
  localparam int PBG_BIT_RECOVERY = 0;
  localparam int PBG_BIT_IRQ_THREE = 2;
  localparam int PBG_BIT_IRQ_ONE_OR_FOUR = 4;
  localparam logic [4:0] PBG_SFE_CAPABLE = 5'h15;
  localparam logic [4:0] PBG_RST_DIR = 5'h00;
  localparam logic [4:0] PBG_RST_OUTPUT = 5'h00;
  localparam logic [4:0] PBG_RST_SFE = 5'h00;
  localparam logic [4:0] PBG_RST_MASK = 5'h00;
  localparam int PBG_SYNC_STAGES = 2;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } pbg_bus_req_t;

  typedef struct packed {
    logic recovery;
    logic irq_three;
    logic irq_one_or_four;
  } pbg_special_t;
endpackage : pbg_pkg
`default_nettype wire

// File: hdl/pbg_sync.sv
// Two-flop synchroniser for a bus of pin levels
`default_nettype none
module pbg_sync
  import pbg_pkg::*;
#(
  parameter int WIDTH = 5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage_one_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_one_reg <= '0;
      sync_o <= '0;
    end else begin
      stage_one_reg <= async_i;
      sync_o <= stage_one_reg;
    end
  end
endmodule : pbg_sync

// File: hdl/pbg_schmitt.sv
// Input buffer model: gated by direction, drives low when disabled
`default_nettype none
module pbg_schmitt
  import pbg_pkg::*;
#(
  parameter int WIDTH = 5
) (
  input wire logic [WIDTH-1:0] pad_i,
  input wire logic [WIDTH-1:0] enable_i,
  output logic [WIDTH-1:0] buf_o
);
  // Disabled buffers read low so an output line never toggles the sampler
  assign buf_o = pad_i & enable_i;
endmodule : pbg_schmitt

// File: sim/pbg_port_sva.sv
// Assertion checker for the port block
`default_nettype none
module pbg_port_sva
  import pbg_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [4:0] PORT_LINE_I,
  input wire logic [4:0] PORT_LINE_O,
  input wire logic [4:0] PORT_LINE_OE_O,
  input wire logic RECOVERY_INPUT_O,
  input wire logic INTERRUPT_REQUEST_THREE_O,
  input wire logic INTERRUPT_REQUEST_ONE_OR_FOUR_O,
  input wire logic IRQ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic done;
  assign done = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  AST_ONE_WAIT: assert property ((AVS_READ_I || AVS_WRITE_I) &&
    AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O) else $error("no answer");
  AST_ACK_PULSE: assert property (!AVS_WAITREQUEST_O |=>
    AVS_WAITREQUEST_O) else $error("waitrequest low too long");
  AST_DIR_WRITE: assert property (done && AVS_ADDRESS_I == PBG_OFF_DIR
    |-> ##2 PORT_LINE_OE_O == $past(AVS_WRITEDATA_I[4:0], 2))
    else $error("enable not per direction");
  AST_OUT_WRITE: assert property (done && AVS_ADDRESS_I == PBG_OFF_OUTPUT
    |-> ##2 PORT_LINE_O == $past(AVS_WRITEDATA_I[4:0], 2))
    else $error("pin not per output");
  AST_RECOVERY: assert property (RECOVERY_INPUT_O |->
    $past(PORT_LINE_I[0], 3)) else $error("recovery without pin");
  AST_IRQ_THREE: assert property (INTERRUPT_REQUEST_THREE_O |->
    $past(PORT_LINE_I[2], 3)) else $error("request three without pin");
  AST_IRQ_ONE_FOUR: assert property (INTERRUPT_REQUEST_ONE_OR_FOUR_O |->
    $past(PORT_LINE_I[4], 3)) else $error("request four without pin");
  AST_SFE_GATE: assert property (done && AVS_ADDRESS_I == PBG_OFF_SFE &&
    !AVS_WRITEDATA_I[0] |-> ##2 !RECOVERY_INPUT_O)
    else $error("recovery not gated");
  AST_MASK_OFF: assert property (done && AVS_ADDRESS_I == PBG_OFF_IRQ_MASK &&
    AVS_WRITEDATA_I[4:0] == 5'h00 |-> ##2 !IRQ_O) else $error("masked irq");
  COV_REC: cover property (RECOVERY_INPUT_O);
  COV_INTERRUPT_REQUEST_THREE: cover property (INTERRUPT_REQUEST_THREE_O);
  COV_IRQ: cover property (IRQ_O);
endmodule : pbg_port_sva
bind pbg_port pbg_port_sva u_sva (.*);
`default_nettype wire

// File: sim/pbg_pins.sv
// Board pin model resolving driven and external levels
`default_nettype none
module pbg_pins (
  input wire logic [4:0] ext_i,
  input wire logic [4:0] out_i,
  input wire logic [4:0] oe_i,
  output logic [4:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : pbg_pins
`default_nettype wire

// File: sim/tb_top.sv
// Top-level testbench for the port block
`default_nettype none
module tb_top;
  import pbg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, rd, wr, wreq, rec, i3, i14, irq;
  logic [3:0] adr;
  logic [31:0] wd, rdat, q;
  logic [4:0] ext, pin, po, poe;
  int num_errors = 0;
  int samples_checked = 0;
  pbg_port u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .PORT_LINE_I(pin),
    .PORT_LINE_O(po), .PORT_LINE_OE_O(poe), .RECOVERY_INPUT_O(rec),
    .INTERRUPT_REQUEST_THREE_O(i3),
    .INTERRUPT_REQUEST_ONE_OR_FOUR_O(i14), .IRQ_O(irq));
  pbg_pins u_pins (.ext_i(ext), .out_i(po), .oe_i(poe), .pin_o(pin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [4:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {27'h0, d};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, string nm);
    bus(1'b0, a, 5'h00);
    chk(nm, q, e);
  endtask : rchk
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask : settle
  task automatic t_reset();
    rchk(PBG_OFF_DIR, 32'h0, "dir");
    rchk(PBG_OFF_OUTPUT, 32'h0, "out");
    rchk(PBG_OFF_SFE, 32'h0, "sfe");
    bus(1'b1, 4'h6, 5'h1F);
    rchk(4'h6, 32'h0, "unmapped");
  endtask : t_reset
  task automatic t_out();
    ext <= 5'h1A;
    bus(1'b1, PBG_OFF_DIR, 5'h05);
    bus(1'b1, PBG_OFF_OUTPUT, 5'h1F);
    bus(1'b1, PBG_OFF_INPUT, 5'h05);
    settle();
    chk("oe", {27'h0, poe}, 32'h05);
    chk("pins", {27'h0, pin}, 32'h1F);
    rchk(PBG_OFF_INPUT, 32'h1F, "input");
  endtask : t_out
  task automatic t_sfe();
    bus(1'b1, PBG_OFF_SFE, 5'h00);
    bus(1'b1, PBG_OFF_DIR, 5'h00);
    ext <= 5'h1F;
    settle();
    bus(1'b1, PBG_OFF_SFE, 5'h1F);
    rchk(PBG_OFF_SFE, 32'h15, "sfe");
    settle();
    chk("special", {29'h0, rec, i3, i14}, 32'h7);
    ext <= 5'h0A;
    settle();
    chk("odd lines", {29'h0, rec, i3, i14}, 32'h0);
    ext <= 5'h1F;
    bus(1'b1, PBG_OFF_SFE, 5'h00);
    settle();
    chk("gated", {29'h0, rec, i3, i14}, 32'h0);
  endtask : t_sfe
  task automatic t_irq();
    bus(1'b1, PBG_OFF_IRQ_MASK, 5'h00);
    bus(1'b1, PBG_OFF_IRQ_STAT, 5'h1F);
    ext <= 5'h1D;
    settle();
    rchk(PBG_OFF_IRQ_STAT, 32'h02, "status");
    chk("masked", {31'h0, irq}, 32'h0);
    bus(1'b1, PBG_OFF_IRQ_MASK, 5'h02);
    settle();
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, PBG_OFF_IRQ_STAT, 5'h02);
    settle();
    chk("cleared", {31'h0, irq}, 32'h0);
    rchk(PBG_OFF_IRQ_STAT, 32'h0, "status");
  endtask : t_irq
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wd = 32'h0;
    ext = 5'h00;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_out();
    t_sfe();
    t_irq();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
